// [hw/dsi_indicator.sv]
`timescale 1ns/1ns
// Overview of operation
// - In normal operation the green indicator flashes briefly every 5 s.
// - In calibration mode the green indicator flashes once per second.
// - An accepted parameter change is confirmed with four green flashes.
// - An insert defect warning flashes the red indicator five times per second; other warnings leave it dark.
// - Insert temperature out of range flashes red once per second as alarm.
// - On alarm the output takes maximum, held last value or user value.
// - During a warning output keeps tracking; warning symbol flashes.
// - During an alarm the alarm symbol is shown steadily with its code.
// - Each error code is a type, alarm or warning, plus a number.
// - Recent errors are kept in a list readable by the operator.
// - Capacitance above range raises alarm 400, below range alarm 403.
// - Probe insulation break raises alarm 428.
// - Level, general and current simulation report warnings 1801, 1802, 1806.
// - Proof test reports warning 429 until it finishes.
// - Checksum failures latch alarm 101 until a total reset.
// - Non-monotonic linearization latches code 1601 until re-entered.
// - Download in progress reports alarm 106 until complete.
module dsi_indicator
    import dsi_pkg::*;
#(
    parameter int TICK_CYCLES = TICK_CYC,
    parameter int HIST_DEPTH = 4
) (
    input wire logic clock,
    input wire logic rst_b,
    input wire logic cap_high,
    input wire logic cap_low,
    input wire logic insul_break,
    input wire logic insert_defect,
    input wire logic temp_out,
    input wire logic csum_fail,
    input wire logic lin_not_mono,
    input wire logic [15:0] meas_value,
    output logic led_green,
    output logic led_red,
    output logic alarm_sym,
    output logic warn_sym,
    output dsi_code_t err_code,
    output logic [15:0] out_value,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready
);
    // Only four history words are addressable, so deeper lists are refused
    if (TICK_CYCLES < 2 || HIST_DEPTH < 1 || HIST_DEPTH > 4) begin : g_bad_params
        $error("dsi_indicator: unsupported parameters");
    end

    logic [31:0] tick_cnt_ff;
    logic tick_ff;
    logic [5:0] ph_op_ff, ph_cal_ff, ph_warn_ff, ph_alm_ff;
    logic [15:0] ctrl_ff, user_ff, hold_ff;
    logic csum_ff, lin_ff;
    logic [3:0] conf_ff;
    dsi_green_t gstate;
    dsi_code_t nxt_code;
    logic any_alarm, any_warn, warn_led;
    dsi_code_t hist_ff [HIST_DEPTH];
    logic wr_go, rd_go;
    logic [31:0] nxt_rdata;
    logic [1:0] nxt_rresp;

    // One timebase for every pattern; a 100 ms tick keeps counters small
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            tick_cnt_ff <= 32'h0;
            tick_ff <= 1'b0;
        end else if (tick_cnt_ff == 32'(TICK_CYCLES - 1)) begin
            tick_cnt_ff <= 32'h0;
            tick_ff <= 1'b1;
        end else begin
            tick_cnt_ff <= tick_cnt_ff + 32'h1;
            tick_ff <= 1'b0;
        end
    end

    // Phase counters, each wrapping at its own period
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            ph_op_ff <= 6'h0;
            ph_cal_ff <= 6'h0;
            ph_warn_ff <= 6'h0;
            ph_alm_ff <= 6'h0;
        end else if (tick_ff) begin
            ph_op_ff <= (ph_op_ff == OP_PER - 6'h1) ? 6'h0 : ph_op_ff + 6'h1;
            ph_cal_ff <= (ph_cal_ff == CAL_PER - 6'h1) ? 6'h0 : ph_cal_ff + 6'h1;
            ph_warn_ff <= (ph_warn_ff == WARN_PER - 6'h1) ? 6'h0 : ph_warn_ff + 6'h1;
            ph_alm_ff <= (ph_alm_ff == ALM_PER - 6'h1) ? 6'h0 : ph_alm_ff + 6'h1;
        end
    end

    // Confirmation burst: eight ticks, lit on even ones, gives four flashes
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            conf_ff <= 4'h0;
        end else if (wr_go && s_axi_awaddr == CTRL_OFS && s_axi_wstrb[1]
                     && s_axi_wdata[CONF_BIT]) begin
            conf_ff <= CONF_TICKS;
        end else if (tick_ff && conf_ff != 4'h0) begin
            conf_ff <= conf_ff - 4'h1;
        end
    end

    // Latched faults; a new failure wins over a clear in the same cycle
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            csum_ff <= 1'b0;
            lin_ff <= 1'b0;
        end else begin
            if (csum_fail) begin
                csum_ff <= 1'b1;
            end else if (wr_go && s_axi_awaddr == CTRL_OFS && s_axi_wstrb[1]
                         && s_axi_wdata[TRST_BIT]) begin
                csum_ff <= 1'b0;
            end
            if (lin_not_mono) begin
                lin_ff <= 1'b1;
            end else if (wr_go && s_axi_awaddr == CTRL_OFS && s_axi_wstrb[1]
                         && s_axi_wdata[LINR_BIT]) begin
                lin_ff <= 1'b0;
            end
        end
    end

    // Error selection in priority order, alarms ahead of warnings
    always_comb begin
        nxt_code = '{is_alarm: 1'b1, num: 16'h0};
        any_alarm = 1'b1;
        any_warn = 1'b0;
        if (csum_ff) nxt_code.num = E_CSUM;
        else if (ctrl_ff[DNLD_BIT]) nxt_code.num = E_DNLD;
        else if (cap_high) nxt_code.num = E_CHI;
        else if (cap_low) nxt_code.num = E_CLO;
        else if (insul_break) nxt_code.num = E_INS;
        else if (temp_out) nxt_code.num = E_TEMP;
        else if (lin_ff) nxt_code.num = E_LIN;
        else begin
            any_alarm = 1'b0;
            nxt_code.is_alarm = 1'b0;
            any_warn = 1'b1;
            if (ctrl_ff[PROOF_BIT]) nxt_code.num = E_PROOF;
            else if (ctrl_ff[LSIM_BIT]) nxt_code.num = E_LSIM;
            else if (ctrl_ff[GSIM_BIT]) nxt_code.num = E_GSIM;
            else if (ctrl_ff[CSIM_BIT]) nxt_code.num = E_CSIM;
            else if (insert_defect) nxt_code.num = E_INSW;
            else any_warn = 1'b0;
        end
    end

    assign warn_led = cap_high | insul_break | insert_defect;
    assign gstate = (conf_ff != 4'h0) ? GR_CONF :
                    ctrl_ff[CAL_BIT] ? GR_CAL : GR_OP;

    // Indicators and display symbols
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            led_green <= 1'b0;
            led_red <= 1'b0;
            alarm_sym <= 1'b0;
            warn_sym <= 1'b0;
            err_code <= '0;
        end else begin
            case (gstate)
                GR_CONF: led_green <= ~conf_ff[0];
                GR_CAL: led_green <= (ph_cal_ff == 6'h0);
                GR_OP: led_green <= (ph_op_ff == 6'h0);
                default: led_green <= 1'b0;
            endcase
            if (any_alarm) led_red <= (ph_alm_ff == 6'h0);
            else if (warn_led) led_red <= (ph_warn_ff == 6'h0);
            else led_red <= 1'b0;
            alarm_sym <= any_alarm;
            warn_sym <= any_warn && (ph_cal_ff < CAL_PER / 6'h2);
            err_code <= nxt_code;
        end
    end

    // Loop output: tracks unless an alarm forces the chosen value
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            hold_ff <= 16'h0;
            out_value <= 16'h0;
        end else if (!any_alarm) begin
            hold_ff <= meas_value;
            out_value <= meas_value;
        end else begin
            case (ctrl_ff[SEL_LSB +: 2])
                SEL_HOLD: out_value <= hold_ff;
                SEL_USER: out_value <= user_ff;
                default: out_value <= OUT_MAX;
            endcase
        end
    end

    // History: a new nonzero code shifts in at the front
    generate
        for (genvar i = 0; i < HIST_DEPTH; i++) begin : g_hist
            always_ff @(posedge clock or negedge rst_b) begin
                if (!rst_b) begin
                    hist_ff[i] <= '0;
                end else if (nxt_code.num != 16'h0 && nxt_code != err_code) begin
                    if (i == 0) hist_ff[i] <= nxt_code;
                    else hist_ff[i] <= hist_ff[(i == 0) ? 0 : i - 1];
                end
            end
        end
    endgenerate

    // Write channel: address and data taken together, one write at a time
    assign wr_go = s_axi_awvalid && s_axi_wvalid && !s_axi_awready && !s_axi_bvalid;
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= RESP_OK;
        end else begin
            s_axi_awready <= wr_go;
            s_axi_wready <= wr_go;
            if (wr_go) begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= (s_axi_awaddr == CTRL_OFS || s_axi_awaddr == USER_OFS)
                               ? RESP_OK : RESP_ERR;
            end else if (s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // Writable registers; command bits 8 to 10 are pulses and not stored
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            ctrl_ff <= CTRL_RST;
            user_ff <= USER_RST;
        end else if (wr_go) begin
            for (int b = 0; b < 2; b++) begin
                if (s_axi_wstrb[b] && s_axi_awaddr == CTRL_OFS)
                    ctrl_ff[b*8 +: 8] <= s_axi_wdata[b*8 +: 8] & (b == 1 ? 8'hF0 : 8'hFF);
                if (s_axi_wstrb[b] && s_axi_awaddr == USER_OFS)
                    user_ff[b*8 +: 8] <= s_axi_wdata[b*8 +: 8];
            end
        end
    end

    // Read decode
    always_comb begin
        nxt_rdata = 32'h0;
        nxt_rresp = RESP_OK;
        if (s_axi_araddr == CTRL_OFS) nxt_rdata = {16'h0, ctrl_ff};
        else if (s_axi_araddr == USER_OFS) nxt_rdata = {16'h0, user_ff};
        else if (s_axi_araddr == STAT_OFS)
            nxt_rdata = {12'h0, csum_ff, lin_ff, any_warn, any_alarm, err_code.num};
        else if (s_axi_araddr[7:5] == 3'h0 && s_axi_araddr[4] &&
                 s_axi_araddr[1:0] == 2'h0 && 32'(s_axi_araddr[3:2]) < HIST_DEPTH)
            nxt_rdata = {15'h0, hist_ff[s_axi_araddr[3:2]]};
        else nxt_rresp = RESP_ERR;
    end

    assign rd_go = s_axi_arvalid && !s_axi_arready && !s_axi_rvalid;
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0;
            s_axi_rresp <= RESP_OK;
        end else begin
            s_axi_arready <= rd_go;
            if (rd_go) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rdata <= nxt_rdata;
                s_axi_rresp <= nxt_rresp;
            end else if (s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end

    default clocking @(posedge clock); endclocking
    default disable iff (!rst_b);
    a_op_flash_slow: assert property (gstate == GR_OP && ph_op_ff != 6'h0
        |=> !led_green) else $error("green op flash outside its slot");
    a_cal_pattern: assert property (tick_ff && gstate == GR_CAL && ph_cal_ff == CAL_PER - 6'h1
        ##1 gstate == GR_CAL |=> led_green) else $error("calib flash missed");
    a_conf_start: assert property (wr_go && s_axi_awaddr == CTRL_OFS && s_axi_wstrb[1]
        && s_axi_wdata[CONF_BIT] |=> conf_ff == CONF_TICKS) else $error("confirm not started");
    a_warn_red: assert property (!any_alarm && warn_led && tick_ff && ph_warn_ff == 6'h1
        ##1 (!any_alarm && warn_led) |=> led_red) else $error("warning red missed");
    a_alarm_red: assert property (any_alarm && tick_ff && ph_alm_ff == ALM_PER - 6'h1
        ##1 any_alarm |=> led_red) else $error("alarm red missed");
    a_alarm_out_max: assert property (any_alarm && ctrl_ff[SEL_LSB +: 2] == SEL_MAX
        |=> out_value == OUT_MAX) else $error("alarm output not max");
    a_track_out: assert property (!any_alarm |=> out_value == $past(meas_value))
        else $error("output not tracking");
    a_alarm_sym: assert property (csum_ff |=> alarm_sym && err_code.is_alarm)
        else $error("alarm symbol missing");
    a_code_cap: assert property (!csum_ff && !ctrl_ff[DNLD_BIT] && cap_high
        |=> err_code.num == E_CHI) else $error("code 400 missing");
    a_csum_sticky: assert property (csum_fail ##1 !wr_go [*2] |=> csum_ff)
        else $error("checksum latch lost");
    a_write_resp: assert property (wr_go |=> s_axi_bvalid && s_axi_awready)
        else $error("write response late");
    c_confirm: cover property (conf_ff == CONF_TICKS ##[1:20] conf_ff == 4'h7);
    c_warn_code: cover property (err_code.num == E_LSIM && !err_code.is_alarm);
    c_alarm_user: cover property (any_alarm && ctrl_ff[SEL_LSB +: 2] == SEL_USER);
    c_hist_read: cover property (rd_go && s_axi_araddr == LAST_OFS);
endmodule : dsi_indicator

// [hw/dsi_pkg.sv]
package dsi_pkg;
    // Clock and timebase
    localparam int CLK_KHZ = 100000;
    localparam int TICK_MS = 100;
    localparam int TICK_CYC = TICK_MS * CLK_KHZ;
    // Flash patterns: period in ms, converted to ticks
    localparam int OP_PER_MS = 5000;
    localparam int CAL_PER_MS = 1000;
    localparam int WARN_PER_MS = 200;
    localparam int ALM_PER_MS = 1000;
    localparam logic [5:0] OP_PER = 6'(OP_PER_MS / TICK_MS);
    localparam logic [5:0] CAL_PER = 6'(CAL_PER_MS / TICK_MS);
    localparam logic [5:0] WARN_PER = 6'(WARN_PER_MS / TICK_MS);
    localparam logic [5:0] ALM_PER = 6'(ALM_PER_MS / TICK_MS);
    localparam logic [3:0] CONF_TICKS = 4'h8;
    // Register byte offsets
    localparam logic [7:0] CTRL_OFS = 8'h00;
    localparam logic [7:0] USER_OFS = 8'h04;
    localparam logic [7:0] STAT_OFS = 8'h08;
    localparam logic [7:0] LAST_OFS = 8'h10;
    // Control fields
    localparam int CAL_BIT = 0;
    localparam int LSIM_BIT = 1;
    localparam int GSIM_BIT = 2;
    localparam int CSIM_BIT = 3;
    localparam int PROOF_BIT = 4;
    localparam int DNLD_BIT = 5;
    localparam int CONF_BIT = 8;
    localparam int TRST_BIT = 9;
    localparam int LINR_BIT = 10;
    localparam int SEL_LSB = 12;
    localparam logic [15:0] CTRL_RST = 16'h0000;
    localparam logic [15:0] USER_RST = 16'h0000;
    localparam logic [15:0] OUT_MAX = 16'h044C;
    // Alarm output selection
    localparam logic [1:0] SEL_MAX = 2'h0;
    localparam logic [1:0] SEL_HOLD = 2'h1;
    localparam logic [1:0] SEL_USER = 2'h2;
    // Error numbers
    localparam logic [15:0] E_CSUM = 16'h0065;
    localparam logic [15:0] E_DNLD = 16'h006A;
    localparam logic [15:0] E_CHI = 16'h0190;
    localparam logic [15:0] E_CLO = 16'h0193;
    localparam logic [15:0] E_INS = 16'h01AC;
    localparam logic [15:0] E_TEMP = 16'h067E;
    localparam logic [15:0] E_LIN = 16'h0641;
    localparam logic [15:0] E_PROOF = 16'h01AD;
    localparam logic [15:0] E_LSIM = 16'h0709;
    localparam logic [15:0] E_GSIM = 16'h070A;
    localparam logic [15:0] E_CSIM = 16'h070E;
    localparam logic [15:0] E_INSW = 16'h01A9;
    localparam logic [1:0] RESP_OK = 2'h0;
    localparam logic [1:0] RESP_ERR = 2'h2;
    typedef struct packed {
        logic is_alarm;
        logic [15:0] num;
    } dsi_code_t;
    typedef enum logic [1:0] {GR_OP, GR_CAL, GR_CONF} dsi_green_t;
endpackage : dsi_pkg

// [verification/dsi_far_side.sv]
`timescale 1ns/1ns
// Display panel and loop output stage, sampling the block at every rising edge
module dsi_far_side
    import dsi_pkg::*;
(
    input wire logic clock,
    input wire logic rst_b,
    input wire logic warn_sym,
    input wire dsi_code_t err_code,
    input wire logic [15:0] out_value,
    output logic [7:0] flash_cnt_ff,
    output dsi_code_t shown_ff,
    output logic [15:0] loop_ff
);
    logic warn_q_ff;

    // Panel latches the code; counting symbol rises proves that it blinks
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            warn_q_ff <= 1'b0;
            flash_cnt_ff <= 8'h00;
            shown_ff <= 17'h00000;
        end else begin
            warn_q_ff <= warn_sym;
            shown_ff <= err_code;
            if (warn_sym && !warn_q_ff) flash_cnt_ff <= flash_cnt_ff + 8'h01;
        end
    end

    // Output stage lags one register, as a real loop driver would
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            loop_ff <= 16'h0000;
        end else begin
            loop_ff <= out_value;
        end
    end
endmodule : dsi_far_side

// [verification/dsi_indicator_tb.sv]
`timescale 1ns/1ns
module dsi_indicator_tb;
    import dsi_pkg::*;
    localparam int TK = 10;
    typedef struct packed {
        logic [4:0] f;
        logic [5:0] c;
        logic a;
        logic [15:0] n;
    } dsi_row_t;
    // Fault order: cap_high, cap_low, insul_break, insert_defect, temp_out
    localparam dsi_row_t ROWS [12] = '{
        '{5'h10, 6'h00, 1'b1, E_CHI},
        '{5'h08, 6'h00, 1'b1, E_CLO},
        '{5'h04, 6'h00, 1'b1, E_INS},
        '{5'h02, 6'h00, 1'b0, E_INSW},
        '{5'h01, 6'h00, 1'b1, E_TEMP},
        '{5'h00, 6'h02, 1'b0, E_LSIM},
        '{5'h00, 6'h04, 1'b0, E_GSIM},
        '{5'h00, 6'h08, 1'b0, E_CSIM},
        '{5'h00, 6'h10, 1'b0, E_PROOF},
        '{5'h00, 6'h20, 1'b1, E_DNLD},
        '{5'h03, 6'h10, 1'b1, E_TEMP},
        '{5'h00, 6'h00, 1'b0, 16'h0000}
    };
    logic clock, rst_b, csum, lin;
    logic led_green, led_red, alarm_sym, warn_sym;
    logic [4:0] flt;
    logic [15:0] meas, out_value, loop_out;
    logic [7:0] awaddr, araddr, flashes, f0;
    logic [31:0] wdata, rdata, rd;
    logic awvalid, awready, wvalid, wready, bvalid, bready;
    logic arvalid, arready, rvalid, rready;
    logic [1:0] bresp, rresp, resp;
    dsi_code_t err_code, shown;
    int mismatches, n_checks, cycles, gl, rl, gr;

    dsi_indicator #(.TICK_CYCLES(TK)) dsi_indicator_i (
        .clock(clock), .rst_b(rst_b), .cap_high(flt[4]), .cap_low(flt[3]),
        .insul_break(flt[2]), .insert_defect(flt[1]), .temp_out(flt[0]),
        .csum_fail(csum), .lin_not_mono(lin), .meas_value(meas),
        .led_green(led_green), .led_red(led_red), .alarm_sym(alarm_sym),
        .warn_sym(warn_sym), .err_code(err_code), .out_value(out_value),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
        .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
        .s_axi_rvalid(rvalid), .s_axi_rready(rready)
    );

    dsi_far_side dsi_far_side_i (
        .clock(clock), .rst_b(rst_b), .warn_sym(warn_sym), .err_code(err_code),
        .out_value(out_value), .flash_cnt_ff(flashes), .shown_ff(shown),
        .loop_ff(loop_out)
    );

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("unexpected %s: expected %h, seen %h", what, exp, got);
        end
    endtask : chk

    // Master holds each channel until its own ready, bready until bvalid
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clock);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        forever begin
            @(posedge clock);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
            if (bvalid) begin
                resp = bresp;
                bready <= 1'b0;
                break;
            end
        end
    endtask : wr

    task automatic rdr(input logic [7:0] a);
        @(posedge clock);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        forever begin
            @(posedge clock);
            if (arready) arvalid <= 1'b0;
            if (rvalid) begin
                rd = rdata;
                resp = rresp;
                rready <= 1'b0;
                break;
            end
        end
    endtask : rdr

    // Lit cycles of each LED and green rises over a window
    task automatic leds(input int n);
        logic pg;
        pg = 1'b0;
        gl = 0;
        rl = 0;
        gr = 0;
        repeat (n) begin
            @(posedge clock);
            gl += int'(led_green);
            rl += int'(led_red);
            gr += int'(led_green && !pg);
            pg = led_green;
        end
    endtask : leds

    // Settle one period, then ten periods hold exactly ten lit ticks
    task automatic pat(input logic [5:0] per, input bit grn);
        int n;
        n = int'(per) * TK;
        repeat (n) @(posedge clock);
        leds(10 * n);
        chk(grn ? "green lit" : "red lit", 32'(10 * TK), 32'(grn ? gl : rl));
    endtask : pat

    task automatic end_of_test();
        $display("checks %0d, mismatches %0d", n_checks, mismatches);
        if (mismatches == 0 && n_checks > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask : end_of_test

    initial begin
        clock = 1'b0;
        forever #5 clock = ~clock;
    end

    // Hang guard sized well above the whole sequence
    initial begin
        cycles = 0;
        forever begin
            @(posedge clock);
            cycles++;
            if (cycles == 30000) begin
                mismatches++;
                end_of_test();
            end
        end
    end

    initial begin
        {rst_b, csum, lin, flt, meas, awaddr, araddr, wdata} = '0;
        {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
        repeat (2) @(posedge clock);
        chk("reset outputs", 32'h0, 32'({led_green, led_red, alarm_sym, bvalid, rvalid, out_value}));
        chk("reset code", 32'h0, 32'(err_code));
        rst_b <= 1'b1;
        rdr(CTRL_OFS);
        chk("ctrl reset", 32'(CTRL_RST), rd);
        chk("read resp", 32'(RESP_OK), 32'(resp));
        rdr(USER_OFS);
        chk("user reset", 32'(USER_RST), rd);
        pat(OP_PER, 1'b1);
        wr(CTRL_OFS, 32'h0000_0100);
        chk("write resp", 32'(RESP_OK), 32'(resp));
        leds(95);
        chk("confirm flashes", 32'h4, 32'(gr));
        wr(CTRL_OFS, 32'h0000_0001);
        pat(CAL_PER, 1'b1);
        wr(CTRL_OFS, 32'h0000_0000);
        f0 = flashes;
        flt <= 5'h02;
        pat(WARN_PER, 1'b0);
        chk("warn symbol blinks", 32'h1, 32'(flashes != f0));
        flt <= 5'h03;
        pat(ALM_PER, 1'b0);
        // Alarm rows also prove the maximum output, warning rows live tracking
        for (int i = 0; i < 12; i++) begin
            wr(CTRL_OFS, 32'(ROWS[i].c));
            flt <= ROWS[i].f;
            meas <= 16'h0100 + 16'(i);
            repeat (4) @(posedge clock);
            chk("shown code", 32'({ROWS[i].a, ROWS[i].n}), 32'(shown));
            chk("alarm symbol", 32'(ROWS[i].a), 32'(alarm_sym));
            chk("loop out", 32'(ROWS[i].a ? OUT_MAX : meas), 32'(loop_out));
            rdr(STAT_OFS);
            chk("status", 32'({ROWS[i].a, ROWS[i].n}), {15'h0, rd[16:0]});
        end
        wr(USER_OFS, 32'h0000_0123);
        wr(CTRL_OFS, 32'h0000_2000);
        flt <= 5'h01;
        repeat (4) @(posedge clock);
        chk("user on alarm", 32'h0123, 32'(loop_out));
        flt <= 5'h00;
        meas <= 16'h0200;
        wr(CTRL_OFS, 32'h0000_1000);
        flt <= 5'h01;
        @(posedge clock);
        meas <= 16'h0300;
        repeat (4) @(posedge clock);
        chk("hold on alarm", 32'h0200, 32'(loop_out));
        flt <= 5'h00;
        @(posedge clock);
        csum <= 1'b1;
        lin <= 1'b1;
        @(posedge clock);
        csum <= 1'b0;
        lin <= 1'b0;
        repeat (20) @(posedge clock);
        chk("checksum latch", 32'({1'b1, E_CSUM}), 32'(err_code));
        wr(CTRL_OFS, 32'h0000_0200);
        repeat (4) @(posedge clock);
        chk("lin latch", 32'({1'b1, E_LIN}), 32'(err_code));
        wr(CTRL_OFS, 32'h0000_0400);
        repeat (4) @(posedge clock);
        chk("latches cleared", 32'h0, 32'(err_code));
        flt <= 5'h10;
        repeat (4) @(posedge clock);
        flt <= 5'h04;
        repeat (4) @(posedge clock);
        flt <= 5'h00;
        rdr(LAST_OFS);
        chk("newest error", 32'h0001_01AC, rd);
        rdr(LAST_OFS + 8'h04);
        chk("older error", 32'h0001_0190, rd);
        wr(CTRL_OFS, 32'h0000_2701);
        rdr(CTRL_OFS);
        chk("ctrl readback", 32'h0000_2001, rd);
        wr(STAT_OFS, 32'h0000_FFFF);
        chk("status write resp", 32'(RESP_ERR), 32'(resp));
        rdr(8'h0C);
        chk("unmapped resp", 32'(RESP_ERR), 32'(resp));
        chk("unmapped data", 32'h0, rd);
        // Mid-run reset: all state clears and the timebase restarts at phase 0
        rst_b <= 1'b0;
        repeat (2) @(posedge clock);
        chk("mid reset", 32'h0, 32'({led_green, led_red, alarm_sym, out_value}));
        chk("mid reset code", 32'h0, 32'(err_code));
        rst_b <= 1'b1;
        repeat (2) @(posedge clock);
        chk("green restart", 32'h1, 32'(led_green));
        rdr(LAST_OFS);
        chk("history cleared", 32'h0, rd);
        end_of_test();
    end
endmodule : dsi_indicator_tb
